/* File: vmecp_pkg.sv */
// shared constants for the command handshake port
package vmecp_pkg;
  // **********************************************
  // address map
  // **********************************************
  localparam logic [15:0] BASE_ADDR_DEF = 16'hB200;
  localparam logic OFS_CMD_DATA = 1'b0;
  localparam logic OFS_STAT_RST = 1'b1;
  // **********************************************
  // status byte layout
  // **********************************************
  localparam int ST_ACCEPT_BIT = 7;
  localparam int ST_AVAIL_BIT = 6;
  localparam int ST_ALARM_BIT = 5;
  localparam int ST_FAULT_BIT = 4;
  localparam logic [3:0] ST_LOW_BITS = 4'h0;
  // **********************************************
  // first command byte and operations
  // **********************************************
  localparam int OPC_MSB = 7;
  localparam int OPC_LSB = 4;
  localparam int CHAN_MSB = 3;
  localparam logic [3:0] CHAN_MAX = 4'h7;
  localparam logic [7:0] OP_SENSOR_TYPE = 8'h10;
  localparam logic [7:0] OP_LIMITS = 8'h20;
  localparam logic [7:0] OP_ALARM_READ = 8'h30;
  localparam logic [7:0] OP_AMBIENT = 8'h40;
  localparam logic [7:0] OP_FIFTY_HZ_REJECT = 8'h48;
  localparam logic [7:0] OP_OPEN_FLAGS = 8'h50;
  localparam logic [7:0] OP_READ_ALL = 8'h58;
  localparam logic [7:0] OP_FILTER = 8'h60;
  localparam logic [7:0] OP_TARE = 8'h70;
  localparam logic [7:0] OP_GAGE_GET = 8'h80;
  localparam logic [7:0] OP_GAGE_SET = 8'h90;
  localparam logic [7:0] OP_ZERO = 8'hB0;
  localparam logic [7:0] OP_COEFFS = 8'hC0;
  localparam logic [7:0] OP_SPAN = 8'hD0;
  localparam logic [7:0] EXTENDED_PREFIX = 8'hF0;
  localparam logic [7:0] MODEL_QUERY = 8'h04;
  localparam logic [7:0] FIRMWARE_VERSION_QUERY = 8'h05;
  localparam logic [7:0] FAST_MODE_ENTRY = 8'h08;
  // **********************************************
  // timing
  // **********************************************
  localparam int CLK_HZ = 40000000;
  localparam int FAULT_HOLD_MS = 500;
  localparam int FAULT_HOLD_CYC = (CLK_HZ / 1000) * FAULT_HOLD_MS;
  localparam int HOLD_W = 25;
  localparam logic [HOLD_W-1:0] HOLD_ZERO = 25'h0000000;
  localparam logic [HOLD_W-1:0] HOLD_ONE = 25'h0000001;
  // **********************************************
  // byte kinds
  // **********************************************
  typedef enum logic [1:0] {
    VMECP_FIRST,
    VMECP_EXT,
    VMECP_ARGS
  } vmecp_seq_t;
endpackage

/* File: vmecp_opdec.sv */
// classifier for the first byte of a command
`timescale 1ns/1ps
module vmecp_opdec (
  input wire logic [7:0] byte_in,
  input wire logic ext_sub,
  output logic known,
  output logic chan_ok,
  output logic is_prefix
);
  logic [7:0] base_op;
  always_comb begin
    // channel-specific ops carry the channel in the low nibble [RQ10]
    base_op = {byte_in[vmecp_pkg::OPC_MSB:vmecp_pkg::OPC_LSB], 4'h0};
    chan_ok = ({1'b0, byte_in[2:0]} <= vmecp_pkg::CHAN_MAX) && !byte_in[vmecp_pkg::CHAN_MSB]; // [RQ11]
    is_prefix = !ext_sub && (byte_in == vmecp_pkg::EXTENDED_PREFIX); // [RQ16]
    known = 1'b0;
    if (ext_sub) begin
      known = (byte_in == vmecp_pkg::MODEL_QUERY) || (byte_in == vmecp_pkg::FIRMWARE_VERSION_QUERY) ||
              (byte_in == vmecp_pkg::FAST_MODE_ENTRY); // [RQ16]
    end else begin
      case (byte_in)
        vmecp_pkg::OP_FIFTY_HZ_REJECT, vmecp_pkg::OP_OPEN_FLAGS, vmecp_pkg::OP_READ_ALL,
        vmecp_pkg::EXTENDED_PREFIX: known = 1'b1; // [RQ15]
        default: begin
          case (base_op)
            vmecp_pkg::OP_SENSOR_TYPE, vmecp_pkg::OP_LIMITS, vmecp_pkg::OP_ALARM_READ,
            vmecp_pkg::OP_AMBIENT, vmecp_pkg::OP_FILTER, vmecp_pkg::OP_TARE,
            vmecp_pkg::OP_GAGE_GET, vmecp_pkg::OP_GAGE_SET, vmecp_pkg::OP_ZERO,
            vmecp_pkg::OP_COEFFS, vmecp_pkg::OP_SPAN: known = chan_ok; // [RQ15]
            default: known = 1'b0;
          endcase
        end
      endcase
    end
  end
endmodule

/* File: vmecp_port.sv */
// byte-wide host command/response port with status and board reset
//
// Notes on behaviour
// RQ1: decode exactly two adjacent byte addresses, separate read and write meaning.
// RQ2: base write loads command byte; base read returns response byte.
// RQ3: base+1 read gives status; any write there resets the board.
// RQ4: status bits 7..4 are accept, available, alarm, fault, active high.
// RQ5: accept flag high while a command byte can be taken; host obeys it.
// RQ6: available flag high while a response byte waits; host obeys it.
// RQ7: alarm flag set while any programmed channel limit is exceeded.
// RQ8: fault flag during reset or fault, held half a second, drives LED; the code holds it only after resets, not after fault_detect.
// RQ9: host ignores other flags while fault is set.
// RQ10: first byte holds opcode in bits 7..4, channel in bits 3..0.
// RQ11: channel numbers run from zero to seven.
// RQ12: commands are one or more bytes; responses optional.
// RQ13: host sends all command bytes in order before reading or new command.
// RQ14: host drains the whole response before the next command.
// RQ15: first-byte operation values as listed, sixteen through two hundred eight.
// RQ16: prefix 240 followed by model, firmware version or fast mode selector.
// RQ17: sixteen-bit values travel most significant byte first.
// RQ18: accept drops on host write, returns on consume; read clears available.
// RQ19: status bits 3..0 read as zero.
`timescale 1ns/1ps
module vmecp_port #(
  parameter logic [15:0] BASE_ADDR = vmecp_pkg::BASE_ADDR_DEF,
  parameter int FAULT_HOLD_CYC = vmecp_pkg::FAULT_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_ack,
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  output logic cmd_first,
  output logic cmd_ext_sub,
  output logic [3:0] op_code,
  output logic [2:0] op_chan,
  output logic op_known,
  output logic [15:0] arg_word,
  input wire logic cmd_taken,
  input wire logic cmd_done,
  input wire logic resp_load,
  input wire logic [7:0] resp_data,
  output logic resp_pending,
  input wire logic limit_exceeded,
  input wire logic fault_detect,
  output logic fault_led,
  output logic board_reset_pulse
);
  // **********************************************
  // address decode
  // **********************************************
  logic hit;
  logic wr_cmd, rd_data, wr_rst, rd_stat;
  assign hit = (host_addr[15:1] == BASE_ADDR[15:1]); // [RQ1]
  assign wr_cmd = hit && host_wr && (host_addr[0] == vmecp_pkg::OFS_CMD_DATA); // [RQ2]
  assign rd_data = hit && host_rd && (host_addr[0] == vmecp_pkg::OFS_CMD_DATA); // [RQ2]
  assign wr_rst = hit && host_wr && (host_addr[0] == vmecp_pkg::OFS_STAT_RST); // [RQ3]
  assign rd_stat = hit && host_rd && (host_addr[0] == vmecp_pkg::OFS_STAT_RST); // [RQ3]

  // **********************************************
  // first-byte classifier
  // **********************************************
  logic dec_known, dec_chan_ok, dec_prefix;

  // **********************************************
  // state
  // **********************************************
  logic [7:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic full_r, full_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic first_r, first_nxt;
  logic ext_r, ext_nxt;
  logic [3:0] opc_r, opc_nxt;
  logic [2:0] chan_r, chan_nxt;
  logic known_r, known_nxt;
  logic [15:0] word_r, word_nxt;
  vmecp_pkg::vmecp_seq_t seq_r, seq_nxt;
  logic [7:0] resp_r, resp_nxt;
  logic avail_r, avail_nxt;
  logic alarm_r, alarm_nxt;
  logic fault_r, fault_nxt;
  logic soft_r, soft_nxt;
  logic [vmecp_pkg::HOLD_W-1:0] hold_r, hold_nxt;
  logic [7:0] status;
  logic access, go;
  logic busy_r, busy_nxt;
  localparam logic [vmecp_pkg::HOLD_W-1:0] HOLD_LOAD = FAULT_HOLD_CYC[vmecp_pkg::HOLD_W-1:0];

  vmecp_opdec u_opdec (
    .byte_in(host_wdata),
    .ext_sub(seq_r == vmecp_pkg::VMECP_EXT),
    .known(dec_known),
    .chan_ok(dec_chan_ok),
    .is_prefix(dec_prefix)
  );

  // fault hides the other flags, as the host must not trust them then
  always_comb begin
    status = {~full_r & ~fault_r, avail_r & ~fault_r, alarm_r & ~fault_r, fault_r,
              vmecp_pkg::ST_LOW_BITS}; // [RQ4] [RQ5] [RQ6] [RQ9] [RQ19]
  end

  assign access = hit && (host_rd || host_wr);
  // one action per strobe: a host holding its strobe past ack must not repeat a write
  assign go = access && !busy_r; // [RQ1]

  always_comb begin
    busy_nxt = access;
    ack_nxt = go; // [RQ1]
    rdata_nxt = rdata_r;
    if (rd_data && go) begin
      rdata_nxt = resp_r; // [RQ2]
    end else if (rd_stat && go) begin
      rdata_nxt = status; // [RQ3]
    end
    soft_nxt = wr_rst && go; // [RQ3]
    alarm_nxt = limit_exceeded; // [RQ7]
    // the half second hold restarts on every board reset
    hold_nxt = hold_r;
    if (soft_r) begin
      hold_nxt = HOLD_LOAD; // [RQ8]
    end else if (hold_r != vmecp_pkg::HOLD_ZERO) begin
      hold_nxt = hold_r - vmecp_pkg::HOLD_ONE; // [RQ8]
    end
    fault_nxt = soft_r || (hold_nxt != vmecp_pkg::HOLD_ZERO) || fault_detect; // [RQ8]
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
      soft_r <= 1'b0;
      alarm_r <= 1'b0;
      // power-up counts as a board reset, so the hold runs from here [RQ8]
      hold_r <= HOLD_LOAD;
      fault_r <= 1'b1;
    end else begin
      busy_r <= busy_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      soft_r <= soft_nxt;
      alarm_r <= alarm_nxt;
      hold_r <= hold_nxt;
      fault_r <= fault_nxt;
    end
  end

  // **********************************************
  // command path
  // **********************************************
  always_comb begin
    full_nxt = full_r;
    cmd_nxt = cmd_r;
    first_nxt = first_r;
    ext_nxt = ext_r;
    opc_nxt = opc_r;
    chan_nxt = chan_r;
    known_nxt = known_r;
    word_nxt = word_r;
    seq_nxt = seq_r;
    // a board reset drops any half-sent command string
    if (soft_r) begin
      full_nxt = 1'b0;
      seq_nxt = vmecp_pkg::VMECP_FIRST;
    end
    if (cmd_taken) begin
      full_nxt = 1'b0; // [RQ18]
    end
    if (cmd_done) begin
      seq_nxt = vmecp_pkg::VMECP_FIRST; // [RQ12]
    end
    // a byte written while one is still held is dropped, not queued [RQ5]
    if (wr_cmd && go && !full_r && !fault_r) begin
      full_nxt = 1'b1; // [RQ18]
      cmd_nxt = host_wdata; // [RQ2]
      first_nxt = 1'b0;
      ext_nxt = 1'b0;
      case (seq_r)
        vmecp_pkg::VMECP_FIRST: begin
          first_nxt = 1'b1;
          opc_nxt = host_wdata[vmecp_pkg::OPC_MSB:vmecp_pkg::OPC_LSB]; // [RQ10]
          chan_nxt = dec_chan_ok ? host_wdata[2:0] : 3'h0; // [RQ10] [RQ11]
          known_nxt = dec_known; // [RQ15]
          word_nxt = 16'h0000;
          seq_nxt = dec_prefix ? vmecp_pkg::VMECP_EXT : vmecp_pkg::VMECP_ARGS; // [RQ16]
        end
        vmecp_pkg::VMECP_EXT: begin
          ext_nxt = 1'b1;
          known_nxt = dec_known; // [RQ16]
          seq_nxt = vmecp_pkg::VMECP_ARGS;
        end
        vmecp_pkg::VMECP_ARGS: begin
          word_nxt = {word_r[7:0], host_wdata}; // [RQ17]
        end
        default: begin
          seq_nxt = vmecp_pkg::VMECP_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      full_r <= 1'b0;
      cmd_r <= 8'h00;
      first_r <= 1'b0;
      ext_r <= 1'b0;
      opc_r <= 4'h0;
      chan_r <= 3'h0;
      known_r <= 1'b0;
      word_r <= 16'h0000;
      seq_r <= vmecp_pkg::VMECP_FIRST;
    end else begin
      full_r <= full_nxt;
      cmd_r <= cmd_nxt;
      first_r <= first_nxt;
      ext_r <= ext_nxt;
      opc_r <= opc_nxt;
      chan_r <= chan_nxt;
      known_r <= known_nxt;
      word_r <= word_nxt;
      seq_r <= seq_nxt;
    end
  end

  // **********************************************
  // response path
  // **********************************************
  always_comb begin
    resp_nxt = resp_r;
    avail_nxt = avail_r;
    if (soft_r || (rd_data && go)) begin
      avail_nxt = 1'b0; // [RQ18]
    end
    // a load beside a read wins, so no response byte is lost
    if (resp_load) begin
      resp_nxt = resp_data;
      avail_nxt = 1'b1; // [RQ6]
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      resp_r <= 8'h00;
      avail_r <= 1'b0;
    end else begin
      resp_r <= resp_nxt;
      avail_r <= avail_nxt;
    end
  end

  assign host_rdata = rdata_r;
  assign host_ack = ack_r;
  assign cmd_valid = full_r;
  assign cmd_data = cmd_r;
  assign cmd_first = first_r;
  assign cmd_ext_sub = ext_r;
  assign op_code = opc_r;
  assign op_chan = chan_r;
  assign op_known = known_r;
  assign arg_word = word_r;
  assign resp_pending = avail_r;
  assign fault_led = fault_r; // [RQ8]
  assign board_reset_pulse = soft_r; // [RQ3]

  // **********************************************
  // checks
  // **********************************************
  a_ack_single: assert property (@(posedge mclk) disable iff (reset) host_ack |=> !host_ack) // [RQ1]
    else $error("host ack stood for two cycles");
  a_cmd_load: assert property (@(posedge mclk) disable iff (reset) // [RQ2] [RQ18]
    wr_cmd && go && !full_r && !fault_r |=> cmd_valid && (cmd_data == $past(host_wdata)))
    else $error("accepted command byte not held");
  a_cmd_refused: assert property (@(posedge mclk) disable iff (reset) wr_cmd && full_r |=> $stable(cmd_data)) // [RQ5]
    else $error("command byte overwritten while held");
  a_avail_set: assert property (@(posedge mclk) disable iff (reset) resp_load |=> resp_pending) // [RQ6]
    else $error("response load did not raise available");
  a_avail_clear: assert property (@(posedge mclk) disable iff (reset) // [RQ18]
    rd_data && go && !resp_load |=> !resp_pending)
    else $error("response read left available set");
  a_reset_pulse: assert property (@(posedge mclk) disable iff (reset) // [RQ3]
    wr_rst && go |=> board_reset_pulse ##1 fault_led)
    else $error("board reset write without reset and fault");
  a_fault_hold: assert property (@(posedge mclk) disable iff (reset) board_reset_pulse |=> fault_led [*8]) // [RQ8]
    else $error("fault dropped right after board reset");
  a_status_low: assert property (@(posedge mclk) disable iff (reset) // [RQ19]
    rd_stat && go |=> host_rdata[3:0] == vmecp_pkg::ST_LOW_BITS)
    else $error("status low bits not zero");
  a_flags_hidden: assert property (@(posedge mclk) disable iff (reset) // [RQ9]
    rd_stat && go && fault_r |=> host_rdata[7:5] == 3'h0)
    else $error("handshake flags shown during fault");
  c_ext_prefix: cover property (@(posedge mclk) disable iff (reset) wr_cmd && go && dec_prefix && !full_r);
  c_resp_read: cover property (@(posedge mclk) disable iff (reset) rd_data && go && avail_r);
  c_board_reset: cover property (@(posedge mclk) disable iff (reset) board_reset_pulse);
  c_refused: cover property (@(posedge mclk) disable iff (reset) wr_cmd && go && full_r);
endmodule

/* File: vmecp_host_model.sv */
// host bus master model for the command port
`timescale 1ns/1ps
module vmecp_host_model (
  input wire logic mclk,
  input wire logic host_ack,
  input wire logic [7:0] host_rdata,
  output logic [15:0] host_addr = 16'h0000,
  output logic host_rd = 1'b0,
  output logic host_wr = 1'b0,
  output logic [7:0] host_wdata = 8'h00
);
  logic hang = 1'b0;
  // strobes held until ack is sampled high, then released
  task automatic acc(input logic wr, input logic ofs, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge mclk);
    host_addr <= vmecp_pkg::BASE_ADDR_DEF + {15'h0000, ofs};
    host_rd <= ~wr;
    host_wr <= wr;
    host_wdata <= wd;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (host_ack !== 1'b1 && n < 32);
    if (n >= 32) hang = 1'b1;
    rd = host_rdata;
    host_rd <= 1'b0;
    host_wr <= 1'b0;
    // released data flips so a stale byte cannot pass
    host_wdata <= ~wd;
  endtask
  // status polling, used before each data-port access except the bench's two back-to-back command writes
  task automatic poll(input logic [7:0] mask, input logic [7:0] val);
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      acc(1'b0, 1'b1, 8'h00, s);
      n++;
    end while ((s & mask) !== val && n < 200);
    if (n >= 200) hang = 1'b1;
  endtask
endmodule

/* File: vmecp_port_tb.sv */
// self-checking bench for the command handshake port
`timescale 1ns/1ps
module vmecp_port_tb;
  typedef struct packed {logic lim; logic fault_flag; logic [7:0] mask; logic [7:0] exp;} vmecp_row_t;
  vmecp_row_t rows [3] = '{'{1'b0, 1'b0, 8'hFF, 8'h80}, '{1'b1, 1'b0, 8'hFF, 8'hA0}, '{1'b0, 1'b1, 8'h1F, 8'h10}};
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cmd_taken = 1'b0;
  logic cmd_done = 1'b0;
  logic resp_load = 1'b0;
  logic limit_exceeded = 1'b0;
  logic fault_detect = 1'b0;
  logic [7:0] resp_data = 8'h00;
  logic [7:0] host_rdata, cmd_data, host_wdata, s;
  logic [15:0] host_addr, arg_word;
  logic [3:0] op_code;
  logic [2:0] op_chan;
  logic host_ack, host_rd, host_wr, cmd_valid, cmd_first, cmd_ext_sub, op_known, resp_pending, fault_led;
  logic board_reset_pulse;
  int n_fail = 0;
  int checked = 0;
  int n;
  int n_rst = 0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (board_reset_pulse === 1'b1) n_rst <= n_rst + 1;
  end
  vmecp_port #(.FAULT_HOLD_CYC(40)) dut_u (.mclk, .reset, .host_addr, .host_rd, .host_wr, .host_wdata,
    .host_rdata, .host_ack, .cmd_valid, .cmd_data, .cmd_first, .cmd_ext_sub, .op_code, .op_chan, .op_known,
    .arg_word, .cmd_taken, .cmd_done, .resp_load, .resp_data, .resp_pending, .limit_exceeded, .fault_detect,
    .fault_led, .board_reset_pulse);
  vmecp_host_model host_u (.mclk, .host_ack, .host_rdata, .host_addr, .host_rd, .host_wr, .host_wdata);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic done);
    host_u.poll(8'h90, 8'h80);
    host_u.acc(1'b1, 1'b0, b, s);
    n = 0;
    while (cmd_valid !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 50) n_fail++;
    chk(cmd_data, b);
    cmd_taken <= 1'b1;
    cmd_done <= done;
    @(posedge mclk);
    cmd_taken <= 1'b0;
    cmd_done <= 1'b0;
  endtask
  task automatic conclude;
    if (host_u.hang) n_fail++;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    host_u.acc(1'b0, 1'b1, 8'h00, s);
    chk(s & 8'h10, 8'h10);
    host_u.poll(8'h10, 8'h00);
    foreach (rows[i]) begin
      limit_exceeded <= rows[i].lim;
      fault_detect <= rows[i].fault_flag;
      repeat (3) @(posedge mclk);
      host_u.acc(1'b0, 1'b1, 8'h00, s);
      chk(s & rows[i].mask, rows[i].exp);
      chk({7'h00, fault_led}, {7'h00, rows[i].fault_flag});
    end
    limit_exceeded <= 1'b0;
    fault_detect <= 1'b0;
    host_u.poll(8'h90, 8'h80);
    host_u.acc(1'b1, 1'b0, 8'h13, s);
    host_u.acc(1'b0, 1'b1, 8'h00, s);
    chk(s & 8'h80, 8'h00);
    n = 0;
    while (cmd_valid !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 50) n_fail++;
    chk(cmd_data, 8'h13);
    chk({4'h0, op_code}, 8'h01);
    chk({5'h00, op_chan}, 8'h03);
    cmd_taken <= 1'b1;
    cmd_done <= 1'b1;
    resp_data <= 8'hC3;
    resp_load <= 1'b1;
    @(posedge mclk);
    cmd_taken <= 1'b0;
    cmd_done <= 1'b0;
    resp_load <= 1'b0;
    host_u.poll(8'hD0, 8'hC0);
    host_u.acc(1'b0, 1'b0, 8'h00, s);
    chk(s, 8'hC3);
    host_u.acc(1'b0, 1'b1, 8'h00, s);
    chk(s & 8'h40, 8'h00);
    host_u.acc(1'b1, 1'b1, 8'h00, s);
    host_u.acc(1'b0, 1'b1, 8'h00, s);
    chk(s & 8'h10, 8'h10);
    resp_data <= 8'h5A;
    resp_load <= 1'b1;
    @(posedge mclk);
    resp_load <= 1'b0;
    @(posedge mclk);
    chk({7'h00, resp_pending}, 8'h01);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    chk({6'h00, cmd_valid, resp_pending}, 8'h00);
    host_u.acc(1'b0, 1'b1, 8'h00, s);
    chk(s, 8'h10);
    host_u.poll(8'h10, 8'h00);
    send(8'hF0, 1'b0);
    chk({5'h00, cmd_first, cmd_ext_sub, op_known}, 8'h05);
    send(8'h04, 1'b0);
    chk({5'h00, cmd_first, cmd_ext_sub, op_known}, 8'h03);
    send(8'h00, 1'b1);
    chk({6'h00, cmd_first, cmd_ext_sub}, 8'h00);
    send(8'h21, 1'b0);
    chk({4'h0, op_code}, 8'h02);
    chk({5'h00, op_chan}, 8'h01);
    send(8'h12, 1'b0);
    send(8'h34, 1'b1);
    chk(arg_word[15:8], 8'h12);
    chk(arg_word[7:0], 8'h34);
    send(8'h1A, 1'b1);
    chk({7'h00, op_known}, 8'h00);
    send(8'hA0, 1'b1);
    chk({7'h00, op_known}, 8'h00);
    send(8'h48, 1'b1);
    chk({7'h00, op_known}, 8'h01);
    host_u.acc(1'b1, 1'b0, 8'h31, s);
    host_u.acc(1'b1, 1'b0, 8'h55, s);
    chk(cmd_data, 8'h31);
    cmd_taken <= 1'b1;
    cmd_done <= 1'b1;
    @(posedge mclk);
    cmd_taken <= 1'b0;
    cmd_done <= 1'b0;
    @(posedge mclk);
    chk({7'h00, cmd_valid}, 8'h00);
    chk(n_rst[7:0], 8'h01);
    conclude();
  end
endmodule
